// ### logic/pmtp_params.svh
/*
 * Constants of the paged map translate and protect block: page word
 * layout, command codes, key codes and cycle counts.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef PMTP_PARAMS_SVH
`define PMTP_PARAMS_SVH

// Page word layout
`define PMTP_LOCK_LSB 0
`define PMTP_LOCK_W 4
`define PMTP_EW_BIT 4
`define PMTP_RSVD_LSB 5
`define PMTP_RSVD_W 3
`define PMTP_PPA_LSB 8
`define PMTP_PPA_W 8
`define PMTP_PAGE_RESET 16'h0000

// Address split
`define PMTP_OFFS_W 12
`define PMTP_PHYS_W 20

// I/O command high byte
`define PMTP_CMD_WR_INSTR 8'h51
`define PMTP_CMD_WR_OPER 8'h52
`define PMTP_CMD_RD_INSTR 8'hd1
`define PMTP_CMD_RD_OPER 8'hd2

// Key and lock codes
`define PMTP_KEY_MASTER 4'h0
`define PMTP_LOCK_OPEN 4'hf

// Cycle counts at ref_clk, counted from the strobe seen high
`define PMTP_HIT_CYC 3'h3
`define PMTP_MISS_CYC 3'h4
`define PMTP_IO_WR_CYC 3'h2

`endif

// ### logic/pmtp_pkg.sv
/*
 * Types of the paged map translate and protect block.
 * Assumes pmtp_params.svh on the include path.
 */
`include "pmtp_params.svh"

package pmtp_pkg;

	// One page map entry as held in the map RAMs
	typedef struct packed {
		logic [`PMTP_PPA_W-1:0] phys_page_field;
		logic [`PMTP_RSVD_W-1:0] rsvd;
		logic ew_protect;
		logic [`PMTP_LOCK_W-1:0] lock_field;
	} pmtp_page_s;

	// Protection bits kept by a cache latch
	typedef struct packed {
		logic ew_protect;
		logic [`PMTP_LOCK_W-1:0] lock_field;
	} pmtp_prot_s;

	// Pins sampled from the processor bus and the map RAMs
	typedef struct packed {
		logic addr_strobe;
		logic data_strobe_n;
		logic rd_wr;
		logic mem_io;
		logic data_instr;
		logic bus_busy_n;
		logic [3:0] addr_state_bits;
		logic [3:0] key_in;
		logic [15:0] info;
		logic [15:0] map_word;
	} pmtp_pins_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_MEM_WAIT = 3'b001,
		ST_IO_ADDR = 3'b010,
		ST_IO_DATA = 3'b011,
		ST_END = 3'b100
	} pmtp_state_e;

endpackage : pmtp_pkg

// ### logic/pmtp_cache_latch.sv
/*
 * One per-space cache latch: tag of the last map lookup and its
 * protection bits, with a combinational hit compare.
 * Assumes load is a one-cycle pulse on the same clock.
 */
`include "pmtp_params.svh"

module pmtp_cache_latch #(
	parameter int TAG_W = 8
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic [TAG_W-1:0] tag_in,
	input wire pmtp_pkg::pmtp_prot_s prot_in,
	input wire logic [TAG_W-1:0] query,
	output logic hit,
	output pmtp_pkg::pmtp_prot_s prot_out
);

	logic valid;
	logic [TAG_W-1:0] tag;

	// Reset empties the latch so the first access looks up the map
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			valid <= 1'b0;
		end else if (load) begin
			valid <= 1'b1;
		end
	end

	// Tag and protection bits of the most recent lookup
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tag <= '0;
			prot_out <= '0;
		end else if (load) begin
			tag <= tag_in;
			prot_out <= prot_in;
		end
	end

	// Hit only on an exact match of state bits and top address bits
	assign hit = valid && (tag == query);

endmodule : pmtp_cache_latch

// ### logic/pmtp_top.sv
/*
 * Paged map translate and protect block: address translation through
 * external map RAMs, key/lock and execute/write checks, per-space cache
 * latches, and page register I/O command handling.
 * Assumes a multiplexed processor bus and map RAMs whose data outputs
 * feed map_word; open-collector lines are resolved outside.
 */
// Functional notes
// - Physical page above twelve offset bits
// - Extended address stable from valid to end
// - Read back lock and execute/write bit
// - Two cache latches, instruction and data
// - Hit when state and page bits match
// - Drive map RAM and transceiver controls
// - Hold address ready low until valid
// - Pull protect fault low on violation
// - Address ready and fault lines are wired-OR
// - Page word: page, reserved, protect, lock
// - Reserved bits may extend the page
// - Decode page register write/read commands
// - 512 registers, 32 groups of 16
// - State bits plus space pick group
// - Execute and write protect checks
// - Key zero opens every lock
// - Keys one to fourteen: own or open
// - Key fifteen only on open lock
// - Reset held at least four cycles
// - Address latched when strobe falls
// - Data ready low only on map writes
// - State changes on rising clock edge
`include "pmtp_params.svh"

module pmtp_top #(
	parameter bit EXT_PAGE_EN = 1'b0,
	parameter logic [2:0] HIT_CYC = `PMTP_HIT_CYC,
	parameter logic [2:0] MISS_CYC = `PMTP_MISS_CYC,
	parameter logic [2:0] IO_WR_CYC = `PMTP_IO_WR_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic addr_strobe,
	input wire logic data_strobe_n,
	input wire logic rd_wr,
	input wire logic mem_io,
	input wire logic data_instr,
	input wire logic bus_busy_n,
	input wire logic [3:0] addr_state_bits,
	input wire logic [3:0] key_in,
	input wire logic [15:0] info_bus,
	input wire logic [15:0] map_word,
	output logic [3:0] page_addr,
	output logic [3:0] data_addr,
	output logic [3:0] instr_addr,
	output logic data_we_n,
	output logic instr_we_n,
	output logic data_oe_n,
	output logic instr_oe_n,
	output logic buf_oe_n,
	output logic addr_valid_out,
	output logic [22:0] phys_addr,
	output logic addr_phase_ready_o,
	output logic addr_phase_ready_oe,
	output logic protect_fault_n_o,
	output logic protect_fault_n_oe,
	output logic data_phase_ready_o,
	output logic data_phase_ready_oe
);

	// Idle levels of the sampled pins, so leaving reset makes no false strobe or busy edge
	localparam pmtp_pkg::pmtp_pins_s PINS_IDLE = '{data_strobe_n: 1'b1, bus_busy_n: 1'b1, default: '0};

	// Key/lock acceptance, shared by the hit and the miss path
	function automatic logic key_ok(input logic [3:0] key, input logic [3:0] lock);
		key_ok = (key == `PMTP_KEY_MASTER)
			|| (lock == `PMTP_LOCK_OPEN)
			|| (key == lock);
	endfunction : key_ok

	// Full violation test for one access
	function automatic logic violation(input logic [3:0] key, input pmtp_pkg::pmtp_prot_s prot,
			input logic is_data, input logic is_write);
		logic ew_hit;
		ew_hit = prot.ew_protect && (is_write || !is_data);
		violation = !key_ok(key, prot.lock_field) || ew_hit;
	endfunction : violation

	pmtp_pkg::pmtp_pins_s pins_raw;
	pmtp_pkg::pmtp_pins_s pins_meta;
	pmtp_pkg::pmtp_pins_s pins;
	pmtp_pkg::pmtp_state_e state;
	pmtp_pkg::pmtp_page_s page_word;
	pmtp_pkg::pmtp_prot_s new_prot;
	pmtp_pkg::pmtp_prot_s use_prot;
	pmtp_pkg::pmtp_prot_s cache_prot [2];
	logic [1:0] cache_hit;
	logic [1:0] cache_load;
	logic [7:0] query_tag;
	logic strobe_prev;
	logic dstrobe_prev;
	logic busy_prev;
	logic strobe_rise;
	logic dstrobe_rise;
	logic busy_rise;
	logic [15:0] addr_hold;
	logic [7:0] cyc_tag;
	logic cyc_mem;
	logic cyc_data;
	logic cyc_write;
	logic cyc_hit;
	logic [2:0] wait_cnt;
	logic fault;
	logic io_write;
	logic io_oper;
	logic mmu_cmd;
	logic [7:0] cmd_byte;

	assign pins_raw = '{addr_strobe: addr_strobe, data_strobe_n: data_strobe_n, rd_wr: rd_wr,
		mem_io: mem_io, data_instr: data_instr, bus_busy_n: bus_busy_n,
		addr_state_bits: addr_state_bits, key_in: key_in, info: info_bus, map_word: map_word};

	// Two-flop sampling of every pin; only the second stage is read
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			// Both stages are flushed well inside the four reset cycles
			pins_meta <= PINS_IDLE;
			pins <= PINS_IDLE;
		end else begin
			pins_meta <= pins_raw;
			pins <= pins_meta;
		end
	end

	// Edge history of the strobes and the busy line
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			strobe_prev <= 1'b0;
			dstrobe_prev <= 1'b1;
			busy_prev <= 1'b1;
		end else begin
			strobe_prev <= pins.addr_strobe;
			dstrobe_prev <= pins.data_strobe_n;
			busy_prev <= pins.bus_busy_n;
		end
	end

	assign strobe_rise = pins.addr_strobe && !strobe_prev;
	assign dstrobe_rise = pins.data_strobe_n && !dstrobe_prev;
	assign busy_rise = pins.bus_busy_n && !busy_prev;

	// Address follows the bus while the strobe is high, frozen by its fall
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			addr_hold <= '0;
		end else if (pins.addr_strobe) begin
			addr_hold <= pins.info;
		end
	end

	// Command decode on the sampled bus word
	assign cmd_byte = pins.info[15:8];
	assign mmu_cmd = (cmd_byte == `PMTP_CMD_WR_INSTR) || (cmd_byte == `PMTP_CMD_WR_OPER)
		|| (cmd_byte == `PMTP_CMD_RD_INSTR) || (cmd_byte == `PMTP_CMD_RD_OPER);

	// Group is state bits plus space; register is the top address nibble
	assign query_tag = {pins.addr_state_bits, pins.info[15:12]};
	assign page_word = pins.map_word;
	assign new_prot = '{ew_protect: page_word.ew_protect, lock_field: page_word.lock_field};
	assign use_prot = cyc_hit ? cache_prot[cyc_data] : new_prot;

	// One cache latch per space; a miss refills only its own space
	generate
		for (genvar sp = 0; sp < 2; sp++) begin : g_cache
			assign cache_load[sp] = (state == pmtp_pkg::ST_MEM_WAIT) && (wait_cnt == 3'h0)
				&& !cyc_hit && (cyc_data == 1'(sp));
			pmtp_cache_latch #(
				.TAG_W(8)
			) u_cache (
				.ref_clk(ref_clk),
				.sys_rst(sys_rst),
				.load(cache_load[sp]),
				.tag_in(cyc_tag),
				.prot_in(new_prot),
				.query(query_tag),
				.hit(cache_hit[sp]),
				.prot_out(cache_prot[sp])
			);
		end
	endgenerate

	// Cycle sequencer: lookup, I/O command, then wait for bus release
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= pmtp_pkg::ST_IDLE;
			wait_cnt <= 3'h0;
		end else begin
			case (state)
				pmtp_pkg::ST_IDLE: begin
					if (strobe_rise && pins.mem_io) begin
						state <= pmtp_pkg::ST_MEM_WAIT;
						wait_cnt <= cache_hit[pins.data_instr] ? HIT_CYC : MISS_CYC;
					end else if (strobe_rise && mmu_cmd) begin
						state <= pmtp_pkg::ST_IO_ADDR;
					end else if (strobe_rise) begin
						state <= pmtp_pkg::ST_END;
					end
				end
				pmtp_pkg::ST_MEM_WAIT: begin
					if (wait_cnt == 3'h0) begin
						state <= pmtp_pkg::ST_END;
					end else begin
						wait_cnt <= wait_cnt - 3'h1;
					end
				end
				pmtp_pkg::ST_IO_ADDR: begin
					state <= pmtp_pkg::ST_IO_DATA;
					wait_cnt <= IO_WR_CYC;
				end
				pmtp_pkg::ST_IO_DATA: begin
					if (dstrobe_rise) begin
						state <= pmtp_pkg::ST_END;
					end else if (!pins.data_strobe_n && wait_cnt != 3'h0) begin
						wait_cnt <= wait_cnt - 3'h1;
					end
				end
				pmtp_pkg::ST_END: begin
					if (busy_rise) begin
						state <= pmtp_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= pmtp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Attributes of the cycle taken at the strobe
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cyc_tag <= '0;
			cyc_mem <= 1'b0;
			cyc_data <= 1'b0;
			cyc_write <= 1'b0;
			cyc_hit <= 1'b0;
			io_write <= 1'b0;
			io_oper <= 1'b0;
		end else if (state == pmtp_pkg::ST_IDLE && strobe_rise) begin
			cyc_tag <= query_tag;
			cyc_mem <= pins.mem_io;
			cyc_data <= pins.data_instr;
			cyc_write <= !pins.rd_wr;
			cyc_hit <= cache_hit[pins.data_instr];
			io_write <= !cmd_byte[7];
			io_oper <= cmd_byte[1];
		end else if (state == pmtp_pkg::ST_END && busy_rise) begin
			cyc_mem <= 1'b0;
		end
	end

	// Map RAM addresses: lookup uses state and page, commands use X and Y
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			page_addr <= 4'h0;
			data_addr <= 4'h0;
			instr_addr <= 4'h0;
		end else if (state == pmtp_pkg::ST_IDLE && strobe_rise && pins.mem_io) begin
			page_addr <= pins.addr_state_bits;
			data_addr <= pins.info[15:12];
			instr_addr <= pins.info[15:12];
		end else if (state == pmtp_pkg::ST_IDLE && strobe_rise && mmu_cmd) begin
			page_addr <= pins.info[7:4];
			data_addr <= pins.info[3:0];
			instr_addr <= pins.info[3:0];
		end
	end

	// Physical address and fault, held until the bus cycle ends
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			addr_valid_out <= 1'b0;
			phys_addr <= '0;
			fault <= 1'b0;
		end else if (state == pmtp_pkg::ST_MEM_WAIT && wait_cnt == 3'h0) begin
			addr_valid_out <= 1'b1;
			phys_addr[19:0] <= {page_word.phys_page_field, addr_hold[`PMTP_OFFS_W-1:0]};
			phys_addr[22:20] <= EXT_PAGE_EN ? page_word.rsvd : 3'h0;
			fault <= violation(pins.key_in, use_prot, cyc_data, cyc_write);
		end else if (state == pmtp_pkg::ST_END && busy_rise) begin
			addr_valid_out <= 1'b0;
			fault <= 1'b0;
		end
	end

	// Ready held low from idle until translation is done; line is shared
	assign addr_phase_ready_o = 1'b0;
	assign addr_phase_ready_oe = (state == pmtp_pkg::ST_IDLE) || (state == pmtp_pkg::ST_MEM_WAIT)
		|| (state == pmtp_pkg::ST_IO_ADDR);
	assign protect_fault_n_o = 1'b0;
	assign protect_fault_n_oe = fault;

	// Data ready driven only for map commands, low only while writing
	assign data_phase_ready_oe = (state == pmtp_pkg::ST_IO_ADDR) || (state == pmtp_pkg::ST_IO_DATA);
	assign data_phase_ready_o = !io_write || (wait_cnt == 3'h0) || (state == pmtp_pkg::ST_IO_ADDR);

	// Map RAM and transceiver strobes; the transceiver takes its direction from the bus
	always_comb begin
		logic io_phase;
		logic io_strobe;
		io_phase = (state == pmtp_pkg::ST_IO_DATA);
		io_strobe = io_phase && !pins.data_strobe_n;
		buf_oe_n = !((state == pmtp_pkg::ST_IO_ADDR) || io_phase);
		data_we_n = !(io_strobe && io_write && io_oper);
		instr_we_n = !(io_strobe && io_write && !io_oper);
		data_oe_n = !((cyc_mem && cyc_data) || (io_strobe && !io_write && io_oper));
		instr_oe_n = !((cyc_mem && !cyc_data) || (io_strobe && !io_write && !io_oper));
	end

endmodule : pmtp_top

// ### testbench/pmtp_top_props.sv
/* Port checker of the translate and protect block.
   Assumes a bind onto pmtp_top; sees only its ports. */
module pmtp_top_props (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic addr_strobe,
	input wire logic data_instr,
	input wire logic [3:0] addr_state_bits,
	input wire logic [15:0] info_bus,
	input wire logic [3:0] page_addr,
	input wire logic [3:0] data_addr,
	input wire logic [3:0] instr_addr,
	input wire logic data_we_n,
	input wire logic data_oe_n,
	input wire logic buf_oe_n,
	input wire logic addr_valid_out,
	input wire logic [22:0] phys_addr,
	input wire logic addr_phase_ready_o,
	input wire logic addr_phase_ready_oe,
	input wire logic protect_fault_n_o,
	input wire logic protect_fault_n_oe,
	input wire logic data_phase_ready_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// One domain, so clock and reset are stated once
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	AST_PHYS_OFFSET: assert property ($rose(addr_valid_out) |-> phys_addr[11:0] == info_bus[11:0])
		else $error("offset bits not passed");
	AST_PHYS_STABLE: assert property (addr_valid_out && $past(addr_valid_out) |-> $stable(phys_addr))
		else $error("address moved while valid");
	AST_GROUP_PICK: assert property ($rose(addr_valid_out) |-> page_addr == addr_state_bits
		&& (data_instr ? data_addr : instr_addr) == info_bus[15:12]) else $error("map address wrong");
	AST_READY_HELD: assert property (addr_valid_out |-> !addr_phase_ready_oe)
		else $error("ready held while valid");
	AST_FAULT_LOW: assert property (protect_fault_n_oe |-> addr_valid_out && !protect_fault_n_o)
		else $error("fault outside a valid cycle");
	AST_OPEN_COLL: assert property (!addr_phase_ready_o && !protect_fault_n_o)
		else $error("open collector driven high");
	AST_MAP_WRITE: assert property (!data_we_n |-> !buf_oe_n && data_oe_n)
		else $error("map write without buffer");
	AST_DPR_IO: assert property (data_phase_ready_oe |-> !buf_oe_n && !addr_valid_out)
		else $error("data ready driven outside map access");
	AST_STROBE_ANSWER: assert property ($rose(addr_strobe) |-> ##[2:12] !addr_phase_ready_oe)
		else $error("strobe not answered");
	AST_RESET_IDLE: assert property ($fell(sys_rst) |-> addr_phase_ready_oe && !addr_valid_out
		&& !protect_fault_n_oe) else $error("not idle after reset");
	COV_VALID: cover property ($rose(addr_valid_out));
	COV_FAULT: cover property ($rose(protect_fault_n_oe));
	COV_MAP_WRITE: cover property ($fell(data_we_n));
endmodule : pmtp_top_props

bind pmtp_top pmtp_top_props props_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .addr_strobe(addr_strobe),
	.data_instr(data_instr), .addr_state_bits(addr_state_bits), .info_bus(info_bus), .page_addr(page_addr),
	.data_addr(data_addr), .instr_addr(instr_addr), .data_we_n(data_we_n), .data_oe_n(data_oe_n),
	.buf_oe_n(buf_oe_n), .addr_valid_out(addr_valid_out), .phys_addr(phys_addr),
	.addr_phase_ready_o(addr_phase_ready_o), .addr_phase_ready_oe(addr_phase_ready_oe),
	.protect_fault_n_o(protect_fault_n_o), .protect_fault_n_oe(protect_fault_n_oe),
	.data_phase_ready_oe(data_phase_ready_oe));

// ### testbench/pmtp_map_ram_model.sv
/* Map RAM pair with its transceiver, one bank per space.
   Assumes active low RAM strobes settled before each edge. */
module pmtp_map_ram_model (
	input wire logic ref_clk,
	input wire logic [3:0] page_addr,
	input wire logic [3:0] data_addr,
	input wire logic [3:0] instr_addr,
	input wire logic data_we_n,
	input wire logic instr_we_n,
	input wire logic data_oe_n,
	input wire logic instr_oe_n,
	input wire logic buf_oe_n,
	input wire logic [15:0] info_bus,
	output logic [15:0] map_word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] dmem [256];
	logic [15:0] imem [256];
	logic [15:0] last = 16'h5a5a;
	logic [15:0] rd;
	// Group from page lines, register from the space lines
	assign rd = data_oe_n ? imem[{page_addr, instr_addr}] : dmem[{page_addr, data_addr}];
	// Released lines drift, so show the inverse of the last word
	assign map_word = (data_oe_n && instr_oe_n) ? ~last : rd;
	// Writes come from the info bus through the transceiver
	always_ff @(posedge ref_clk) begin
		if (!data_we_n && !buf_oe_n) begin
			dmem[{page_addr, data_addr}] <= info_bus;
		end
		if (!instr_we_n && !buf_oe_n) begin
			imem[{page_addr, instr_addr}] <= info_bus;
		end
		if (!(data_oe_n && instr_oe_n)) begin
			last <= rd;
		end
	end
endmodule : pmtp_map_ram_model

// ### testbench/testbench.sv
/* Self-checking bench of the translate and protect block.
   Assumes default cycle counts and a master holding each request until ready. */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic addr_strobe = 1'b0;
	logic data_strobe_n = 1'b1;
	logic rd_wr = 1'b1;
	logic mem_io = 1'b1;
	logic data_instr = 1'b1;
	logic bus_busy_n = 1'b1;
	logic [3:0] addr_state_bits = 4'h0;
	logic [3:0] key_in = 4'h0;
	logic [15:0] info_bus = 16'h0000;
	logic [15:0] map_word;
	logic [3:0] page_addr, data_addr, instr_addr;
	logic data_we_n, instr_we_n, data_oe_n, instr_oe_n, buf_oe_n, addr_valid_out;
	logic [22:0] phys_addr;
	logic addr_phase_ready_o, addr_phase_ready_oe, protect_fault_n_o, protect_fault_n_oe;
	logic data_phase_ready_o, data_phase_ready_oe;
	int n_mismatch = 0;
	int num_checks = 0;
	logic [31:0] s = 32'h9daf;

	pmtp_top dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .addr_strobe(addr_strobe),
		.data_strobe_n(data_strobe_n), .rd_wr(rd_wr), .mem_io(mem_io), .data_instr(data_instr),
		.bus_busy_n(bus_busy_n), .addr_state_bits(addr_state_bits), .key_in(key_in), .info_bus(info_bus),
		.map_word(map_word), .page_addr(page_addr), .data_addr(data_addr), .instr_addr(instr_addr),
		.data_we_n(data_we_n), .instr_we_n(instr_we_n), .data_oe_n(data_oe_n), .instr_oe_n(instr_oe_n),
		.buf_oe_n(buf_oe_n), .addr_valid_out(addr_valid_out), .phys_addr(phys_addr),
		.addr_phase_ready_o(addr_phase_ready_o), .addr_phase_ready_oe(addr_phase_ready_oe),
		.protect_fault_n_o(protect_fault_n_o), .protect_fault_n_oe(protect_fault_n_oe),
		.data_phase_ready_o(data_phase_ready_o), .data_phase_ready_oe(data_phase_ready_oe));

	pmtp_map_ram_model ram_u (.ref_clk(ref_clk), .page_addr(page_addr), .data_addr(data_addr),
		.instr_addr(instr_addr), .data_we_n(data_we_n), .instr_we_n(instr_we_n), .data_oe_n(data_oe_n),
		.instr_oe_n(instr_oe_n), .buf_oe_n(buf_oe_n), .info_bus(info_bus), .map_word(map_word));

	// Second block with the reserved bits widening the page; it follows the same map word
	logic [22:0] phys_ext;
	pmtp_top #(.EXT_PAGE_EN(1'b1)) ext_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .addr_strobe(addr_strobe),
		.data_strobe_n(data_strobe_n), .rd_wr(rd_wr), .mem_io(mem_io), .data_instr(data_instr),
		.bus_busy_n(bus_busy_n), .addr_state_bits(addr_state_bits), .key_in(key_in), .info_bus(info_bus),
		.map_word(map_word), .page_addr(), .data_addr(), .instr_addr(), .data_we_n(), .instr_we_n(),
		.data_oe_n(), .instr_oe_n(), .buf_oe_n(), .addr_valid_out(), .phys_addr(phys_ext),
		.addr_phase_ready_o(), .addr_phase_ready_oe(), .protect_fault_n_o(), .protect_fault_n_oe(),
		.data_phase_ready_o(), .data_phase_ready_oe());

	// 200 MHz clock
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] nx(input logic [31:0] v);
		nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nx

	// Key zero opens all; open lock takes all; else key must match
	function automatic logic fault_exp(input logic [3:0] key, lock, input logic ew, di, rw);
		fault_exp = !(key == 4'h0 || lock == 4'hf || key == lock) || (ew && (!di || !rw));
	endfunction : fault_exp

	task automatic chk(input logic [22:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Address phase: hold the request until the block lets ready go
	task automatic bus_cyc(input logic mio, di, rw, input logic [3:0] as, key, input logic [15:0] ib, output int n);
		n = 0;
		@(posedge ref_clk);
		mem_io <= mio;
		data_instr <= di;
		rd_wr <= rw;
		addr_state_bits <= as;
		key_in <= key;
		info_bus <= ib;
		bus_busy_n <= 1'b0;
		addr_strobe <= 1'b1;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (addr_phase_ready_oe !== 1'b0 && n < 40);
		chk(n < 40, 1'b1);
	endtask : bus_cyc

	// Data phase; info bus changes only after the strobe has fallen
	task automatic data_ph(input logic [15:0] d, output logic [15:0] rd, output logic dps, output logic dpl);
		dps = 1'b0;
		dpl = 1'b0;
		rd = 16'h0000;
		@(posedge ref_clk);
		addr_strobe <= 1'b0;
		@(posedge ref_clk);
		info_bus <= d;
		data_strobe_n <= 1'b0;
		for (int k = 0; k < 8; k++) begin
			@(posedge ref_clk);
			#1;
			dps |= data_phase_ready_oe;
			dpl |= data_phase_ready_oe && !data_phase_ready_o;
			if (k == 5) rd = map_word;
		end
		@(posedge ref_clk);
		data_strobe_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		bus_busy_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask : data_ph

	task automatic end_of_test();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test

	// Watchdog, far beyond the expected eight microseconds
	initial begin
		#50000;
		n_mismatch++;
		end_of_test();
	end

	// Per lock value: write, read back, then a miss and a hit
	initial begin
		int nn[2];
		logic [15:0] ent, adr, rd;
		logic [3:0] key;
		logic di, rw, dps, dpl, flt;
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		chk(addr_phase_ready_oe, 1'b1);
		for (int i = 0; i < 16; i++) begin
			s = nx(s);
			di = s[13];
			rw = s[14];
			ent = {s[11:4], s[23:21], s[12], i[3:0]};
			adr = {s[3:0], s[31:20]};
			key = i[1:0] == 2'h0 ? 4'h0 : i[1:0] == 2'h1 ? i[3:0] : i[1:0] == 2'h2 ? 4'hf : s[19:16];
			flt = fault_exp(key, i[3:0], s[12], di, rw);
			bus_cyc(1'b0, 1'b1, 1'b0, 4'h0, 4'h0, {di ? 8'h52 : 8'h51, i[3:0], s[3:0]}, nn[0]);
			data_ph(ent, rd, dps, dpl);
			chk(dps, 1'b1);
			chk(dpl, 1'b1);
			bus_cyc(1'b0, 1'b1, 1'b1, 4'h0, 4'h0, {di ? 8'hd2 : 8'hd1, i[3:0], s[3:0]}, nn[0]);
			data_ph(16'h0000, rd, dps, dpl);
			chk(rd, ent);
			chk(dps, 1'b1);
			chk(dpl, 1'b0);
			for (int k = 0; k < 2; k++) begin
				bus_cyc(1'b1, di, rw, i[3:0], key, adr, nn[k]);
				chk(phys_addr, {3'h0, s[11:4], adr[11:0]});
				chk(phys_ext, {s[23:21], s[11:4], adr[11:0]});
				chk(protect_fault_n_oe, flt);
				data_ph(16'h0000, rd, dps, dpl);
				chk(dps, 1'b0);
			end
			chk(nn[0] - nn[1], `PMTP_MISS_CYC - `PMTP_HIT_CYC);
		end
		// A foreign I/O code must leave the data phase alone
		bus_cyc(1'b0, 1'b1, 1'b0, 4'h0, 4'h0, 16'h4000, nn[0]);
		data_ph(16'h1234, rd, dps, dpl);
		chk(dps, 1'b0);
		end_of_test();
	end
endmodule : testbench
